// ---- code_protect_cfg.svh ----
// constants for the code protection gate
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef CODE_PROTECT_CFG_SVH
`define CODE_PROTECT_CFG_SVH
`define CFG_WORD_ADDR 14'h2007
`define ID_FIRST_ADDR 14'h2000
`define ID_LAST_ADDR 14'h2003
`define CFG_SPACE_BIT 13
`define SEG_HALF_BASE 11'h200
`define SEG_QUARTER_BASE 11'h400
`define CAL_ADDR_SMALL 11'h3FF
`define CAL_ADDR_LARGE 11'h7FF
`define CFG_RESET_VALUE 14'h3FFF
`define CP_PAIR_A_LSB 12
`define CP_PAIR_B_LSB 10
`define CP_PAIR_C_LSB 8
`define CP_PAIR_D_LSB 5
`endif

// ---- code_protect_pkg.sv ----
// types for the code protection gate
package code_protect_pkg;
  typedef enum logic [1:0]
  {
    PROT_ALL,
    PROT_HALF,
    PROT_QUARTER,
    PROT_OFF
  } prot_level_e;
endpackage

// ---- code_protect_gate.sv ----
// code protection gate between the programming link and program memory
`timescale 1ns/1ps
`default_nettype none
`include "code_protect_cfg.svh"
module code_protect_gate
  import code_protect_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [13:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [13:0] wdata_in,
  input wire logic [13:0] mem_rdata_in,
  output logic [13:0] rdata_out,
  output logic rvalid_out,
  output logic mem_wr_out,
  output logic [13:0] mem_addr_out,
  output logic [13:0] mem_wdata_out,
  output logic [13:0] device_configuration_word_out,
  output logic [1:0] protect_level_out
);

  // ---------------------------------------------------------------------
  // configuration word register
  // ---------------------------------------------------------------------
  logic [13:0] cfg_r;
  logic is_cfg;
  assign is_cfg = (addr_in == `CFG_WORD_ADDR);

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cfg_r <= `CFG_RESET_VALUE;
    else if (wr_in && is_cfg)
      cfg_r <= wdata_in;
  end

  // ---------------------------------------------------------------------
  // protection level decode
  // ---------------------------------------------------------------------
  logic [1:0] pa, pb, pc, pd;
  logic pairs_agree;
  prot_level_e level;
  assign pa = cfg_r[`CP_PAIR_A_LSB +: 2];
  assign pb = cfg_r[`CP_PAIR_B_LSB +: 2];
  assign pc = cfg_r[`CP_PAIR_C_LSB +: 2];
  assign pd = cfg_r[`CP_PAIR_D_LSB +: 2];
  assign pairs_agree = (pa == pb) && (pa == pc) && (pa == pd);

  always_comb
  begin
    level = PROT_OFF;
    if (pairs_agree)
    begin
      unique case (pa)
        2'h0: level = PROT_ALL;
        2'h1: level = PROT_HALF;
        2'h2: level = LARGE_VARIANT ? PROT_QUARTER : PROT_OFF;
        2'h3: level = PROT_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // segment check
  // ---------------------------------------------------------------------
  logic in_cfg_space, is_cal, prot_hit;
  logic [10:0] paddr;
  assign in_cfg_space = addr_in[`CFG_SPACE_BIT];
  assign paddr = addr_in[10:0];
  assign is_cal = LARGE_VARIANT ? (paddr == `CAL_ADDR_LARGE)
                                : (paddr == `CAL_ADDR_SMALL);

  always_comb
  begin
    prot_hit = 1'b0;
    if (!in_cfg_space && !is_cal)
    begin
      unique case (level)
        PROT_ALL: prot_hit = 1'b1;
        PROT_HALF: prot_hit = (paddr >= `SEG_HALF_BASE);
        PROT_QUARTER: prot_hit = (paddr >= `SEG_QUARTER_BASE);
        PROT_OFF: prot_hit = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // gated memory access
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mem_wr_out <= 1'b0;
      mem_addr_out <= 14'h0000;
      mem_wdata_out <= 14'h0000;
    end
    else
    begin
      mem_wr_out <= wr_in && !prot_hit && !is_cfg;
      mem_addr_out <= addr_in;
      mem_wdata_out <= wdata_in;
    end
  end

  logic hit_q, cfg_q;
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      hit_q <= 1'b0;
      cfg_q <= 1'b0;
      rvalid_out <= 1'b0;
    end
    else
    begin
      hit_q <= prot_hit;
      cfg_q <= is_cfg;
      rvalid_out <= rd_in;
    end
  end

  // read answer two cycles after rd_in (config word after one), memory data arrives with mem_addr_out
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata_out <= 14'h0000;
    else if (rd_in)
      rdata_out <= is_cfg ? cfg_r : 14'h0000;
    else if (rvalid_out && !cfg_q)
      rdata_out <= hit_q ? 14'h0000 : mem_rdata_in;
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      device_configuration_word_out <= `CFG_RESET_VALUE;
      protect_level_out <= 2'h3;
    end
    else
    begin
      device_configuration_word_out <= cfg_r;
      protect_level_out <= level;
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  a_prot_write_blocked: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (wr_in && prot_hit) |=> !mem_wr_out)
    else $error("write reached a protected segment");
  a_prot_read_zero: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (rd_in && prot_hit) |=> ##1 rdata_out == 14'h0)
    else $error("protected read not zero");
  a_open_write_passes: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (wr_in && !in_cfg_space && level == PROT_OFF)
    |=> mem_wr_out && mem_wdata_out == $past(wdata_in))
    else $error("unprotected write lost");
  a_cal_never_protected: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) is_cal |-> !prot_hit)
    else $error("calibration word protected");
  a_cfg_write_stored: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (wr_in && is_cfg) |=> ##1
    device_configuration_word_out == $past(wdata_in, 2))
    else $error("configuration word write lost");
  a_half_boundary: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (level == PROT_HALF && !in_cfg_space &&
    paddr < `SEG_HALF_BASE) |-> !prot_hit)
    else $error("lower half protected");
  a_mismatch_off: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) !pairs_agree |-> level == PROT_OFF)
    else $error("disagreeing pairs enabled protection");
  a_quarter_range: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (level == PROT_QUARTER && !in_cfg_space &&
    !is_cal) |-> prot_hit == (paddr >= `SEG_QUARTER_BASE))
    else $error("quarter range wrong");
  a_cfg_not_mem: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (wr_in && is_cfg) |=> !mem_wr_out)
    else $error("configuration write reached memory");
  a_id_write_passes: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (wr_in && in_cfg_space && !is_cfg)
    |=> mem_wr_out)
    else $error("identification write lost");
  a_all_protected: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (level == PROT_ALL && !in_cfg_space &&
    !is_cal) |-> prot_hit)
    else $error("full protection left a word open");
  a_cal_write_passes: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (wr_in && is_cal && !in_cfg_space)
    |=> mem_wr_out)
    else $error("calibration write lost");
  a_open_read_true: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (rd_in && !prot_hit && !in_cfg_space)
    |=> ##1 rdata_out == $past(mem_rdata_in))
    else $error("unprotected read not true");
  a_cfg_read_true: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) (rd_in && is_cfg) |=> rdata_out == $past(cfg_r))
    else $error("configuration read not true");
  a_level_output: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) 1'b1 |=> protect_level_out == $past(level))
    else $error("protection level output stale");
  a_rvalid_pulse: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) rd_in |=> rvalid_out)
    else $error("read answer missing");
  a_mem_addr_copy: assert property (@(posedge clock_in)
    disable iff (!reset_n_in) 1'b1 |=> mem_addr_out == $past(addr_in))
    else $error("memory address not forwarded");

  // ---------------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------------
  c_prot_read: cover property (@(posedge clock_in) rd_in && prot_hit);
  c_quarter_level: cover property (@(posedge clock_in) level == PROT_QUARTER);
  c_prot_write: cover property (@(posedge clock_in) wr_in && prot_hit);
  c_cfg_write: cover property (@(posedge clock_in) wr_in && is_cfg);
  c_half_level: cover property (@(posedge clock_in) level == PROT_HALF);

endmodule // code_protect_gate
`default_nettype wire

// ---- prog_mem_model.sv ----
// program memory model behind the protection gate
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
(
  input wire logic clock_in,
  input wire logic [13:0] addr_in,
  input wire logic wr_in,
  input wire logic [13:0] wdata_in,
  output logic [13:0] rdata_out
);
  // config space folded in by bit 13
  logic [13:0] mem [4096];
  // blank one-time-programmable words read all ones
  initial
  begin
    foreach (mem[i])
      mem[i] = 14'h3FFF;
  end
  assign rdata_out = mem[{addr_in[13], addr_in[10:0]}];
  always @(posedge clock_in)
  begin
    if (wr_in)
    begin
      mem[{addr_in[13], addr_in[10:0]}] <= wdata_in;
    end
  end
endmodule // prog_mem_model
`default_nettype wire

// ---- code_protect_and_checksum_tb.sv ----
// testbench for the code protection gate
`timescale 1ns/1ps
`default_nettype none
module code_protect_and_checksum_tb;
  logic clock_in = 0, reset_n_in = 0, rd_in = 0, wr_in = 0, rvalid, mem_wr;
  logic [13:0] addr_in = 0, wdata_in = 0, rdata, mem_rd, mem_a, mem_wd;
  logic [13:0] cfg_out, x, got;
  logic [1:0] lvl_out;
  logic p;
  int bad_count = 0, checks = 0;
  logic [13:0] ex [4096];
  logic [13:0] adr [8] = '{14'h000, 14'h1FF, 14'h200, 14'h3FF, 14'h400,
    14'h7FE, 14'h7FF, 14'h2001};
  // all, from 200h, from 400h, pairs disagreeing
  logic [13:0] cfg [4] = '{14'h009F, 14'h15BF, 14'h2ADF, 14'h3F9F};
  always #10 clock_in = ~clock_in;
  code_protect_gate #(.LARGE_VARIANT(1'b1)) u_dut (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .addr_in(addr_in), .rd_in(rd_in),
    .wr_in(wr_in), .wdata_in(wdata_in), .mem_rdata_in(mem_rd),
    .rdata_out(rdata), .rvalid_out(rvalid), .mem_wr_out(mem_wr),
    .mem_addr_out(mem_a), .mem_wdata_out(mem_wd),
    .device_configuration_word_out(cfg_out), .protect_level_out(lvl_out));
  prog_mem_model u_mem (.clock_in(clock_in), .addr_in(mem_a),
    .wr_in(mem_wr), .wdata_in(mem_wd), .rdata_out(mem_rd));
  function automatic int ix(logic [13:0] a);
    return {a[13], a[10:0]};
  endfunction
  function automatic bit prot(int l, logic [13:0] a);
    return !a[13] && a != 14'h7FF && (l == 0 || (l == 1 && a >= 14'h200)
      || (l == 2 && a >= 14'h400));
  endfunction
  task automatic chk(logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      $display("unexpected at %0t: got %h want %h", $time, s, e);
      bad_count++;
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(logic [13:0] a, logic [13:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1;
    @(posedge clock_in);
    wr_in <= 0;
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  task automatic rd(logic [13:0] a, logic [13:0] e);
    int n;
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1;
    @(posedge clock_in);
    rd_in <= 0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n == 4)
    begin
      bad_count++;
      conclude();
    end
    @(posedge clock_in);
    #1;
    got = rdata;
    chk(rdata, e);
  endtask
  // read-back checksum against range-masked checksum of expected image
  task automatic csum(int l);
    logic [15:0] s_exp, s_got, id_exp, id_got;
    int top;
    s_exp = 16'h0000;
    s_got = 16'h0000;
    id_exp = 16'h0000;
    id_got = 16'h0000;
    top = (l == 0) ? -1 : (l == 1) ? 'h1FF : (l == 2) ? 'h3FF : 'h7FE;
    for (int a = 0; a < 'h7FF; a++)
    begin
      rd(14'(a), prot(l, 14'(a)) ? 14'h0000 : ex[a]);
      s_got = s_got + {2'b00, got};
      if (a <= top)
        s_exp = s_exp + {2'b00, ex[a]};
    end
    for (int i = 0; i < 4; i++)
    begin
      rd(14'h2000 + 14'(i), ex[2048 + i]);
      id_got = {id_got[11:0], got[3:0]};
      id_exp = {id_exp[11:0], ex[2048 + i][3:0]};
    end
    rd(14'h2007, cfg[l]);
    s_got = s_got + {2'b00, got & 14'h3FFF};
    s_exp = s_exp + {2'b00, cfg[l] & 14'h3FFF};
    if (l != 3)
    begin
      s_got = s_got + id_got;
      s_exp = s_exp + id_exp;
    end
    chk(s_got, s_exp);
  endtask
  initial
  begin
    foreach (ex[i])
      ex[i] = 14'h3FFF;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1;
    chk(cfg_out, 14'h3FFF);
    foreach (adr[i])
    begin
      ex[ix(adr[i])] = adr[i] ^ 14'h1555;
      wr(adr[i], ex[ix(adr[i])]);
    end
    for (int l = 0; l < 4; l++)
    begin
      wr(14'h2007, cfg[l]);
      chk(cfg_out, cfg[l]);
      chk({12'h000, lvl_out}, 14'(l));
      rd(14'h2007, cfg[l]);
      foreach (adr[i])
      begin
        p = prot(l, adr[i]);
        x = adr[i] ^ cfg[l];
        rd(adr[i], p ? 14'h0000 : ex[ix(adr[i])]);
        wr(adr[i], x);
        if (!p)
          ex[ix(adr[i])] = x;
        chk(u_mem.mem[ix(adr[i])], ex[ix(adr[i])]);
      end
      csum(l);
      $display("level %0d test done", l);
    end
    conclude();
  end
endmodule // code_protect_and_checksum_tb
`default_nettype wire
